/* File: core/cct_timer.sv */
// Cascadable 16-bit compare timer with two 8-bit halves and Avalon-MM slave.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/100ps
module cct_timer (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    output logic [7:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic event_input_pin,
    input wire logic event_rising,
    output logic upper_toggle_pin,
    output logic lower_toggle_pin,
    output logic irq
);
    logic [7:0] timer_control_r;
    logic [7:0] status_r;
    logic [7:0] counter_high_byte_r;
    logic [7:0] counter_low_byte_r;
    logic [7:0] compare_high_byte_r;
    logic [7:0] compare_low_byte_r;
    logic [1:0] irq_request_reg_two_r;
    logic [1:0] irq_enable_reg_two_r;
    logic [7:0] temp_r;
    logic [7:0] flag_seen_r;
    localparam int PRESCALE_DIV_W = cct_pkg::PRESCALE_BITS;
    localparam logic [7:0] IRQ_RST = cct_pkg::IRQ_RST;
    typedef cct_pkg::cct_event_t cct_event_t_alias;
    logic [PRESCALE_DIV_W-1:0] pre_r;
    logic [2:0] evt_sync_r;
    logic pending_r;
    logic wr_r;
    logic rd_r;
    logic [15:0] addr_r;
    logic [7:0] wdata_r;

    logic sixteen;
    logic [PRESCALE_DIV_W-1:0] pre_nxt;
    logic tick_lo;
    logic tick_hi;
    logic lo_wrap;
    logic hi_wrap;
    logic lo_match;
    logic hi_match;
    logic full_match;
    logic lo_clr;
    logic hi_clr;
    logic evt_edge;
    cct_event_t_alias ev_hi;
    cct_event_t_alias ev_lo;
    logic wr_ir;
    logic wr_ie;
    logic rd_ch_now;
    logic rd_ph_now;

    assign sixteen = ~timer_control_r[cct_pkg::TC_UPPER_SEL_TOP];
    assign pre_nxt = pre_r + 5'h01;

    // Rate select: a prescaler bit rising marks one tick of that rate.
    function automatic logic rate_tick(input logic [1:0] sel,
                                       input logic [4:0] now,
                                       input logic [4:0] nxt);
        logic [2:0] b;
        b = 3'h0;
        unique case (sel)
            2'b00: begin
                b = 3'h4;
            end
            2'b01: begin
                b = 3'h3;
            end
            2'b10: begin
                b = 3'h1;
            end
            2'b11: begin
                b = 3'h0;
            end
        endcase
        rate_tick = nxt[b] & ~now[b];
    endfunction : rate_tick

    // The event input is synchronised; only the second stage onward is read.
    always_comb begin
        if (event_rising) begin
            evt_edge = evt_sync_r[1] & ~evt_sync_r[2];
        end else begin
            evt_edge = ~evt_sync_r[1] & evt_sync_r[2];
        end
    end

    always_comb begin
        if (timer_control_r[cct_pkg::TC_LOWER_SEL_TOP]) begin
            tick_lo = rate_tick(timer_control_r[1:0], pre_r, pre_nxt);
        end else begin
            tick_lo = evt_edge;
        end
    end

    assign lo_match = counter_low_byte_r == compare_low_byte_r;
    assign hi_match = counter_high_byte_r == compare_high_byte_r;
    assign full_match = lo_match & hi_match;
    // With its clear bit set, a matched counter is cleared on the next count instead of stepping.
    assign lo_clr = sixteen ? (full_match & status_r[cct_pkg::ST_UPPER_CLR])
                            : (lo_match & status_r[cct_pkg::ST_LOWER_CLR]);
    assign hi_clr = sixteen ? (full_match & status_r[cct_pkg::ST_UPPER_CLR])
                            : (hi_match & status_r[cct_pkg::ST_UPPER_CLR]);
    assign lo_wrap = tick_lo & ~lo_clr & (counter_low_byte_r == 8'hFF);
    always_comb begin
        if (sixteen) begin
            tick_hi = tick_lo & (lo_clr | (counter_low_byte_r == 8'hFF));
        end else begin
            tick_hi = rate_tick(timer_control_r[5:4], pre_r, pre_nxt);
        end
    end
    assign hi_wrap = tick_hi & ~hi_clr & (counter_high_byte_r == 8'hFF);
    // Events are taken on the count edge so that a held match fires once.
    assign ev_hi.ovf = hi_wrap;
    assign ev_hi.cmp = tick_hi & (sixteen ? full_match : hi_match);
    assign ev_lo.ovf = lo_wrap & ~sixteen;
    assign ev_lo.cmp = tick_lo & lo_match & ~sixteen;

    // The prescaler runs free, so the first tick after a select change
    // may come up to one period early.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pre_r <= '0;
            evt_sync_r <= 3'h0;
        end else begin
            pre_r <= pre_nxt;
            evt_sync_r <= {evt_sync_r[1:0], event_input_pin};
        end
    end

    // Bus slave: each request is latched, answered one cycle later.
    logic take;
    logic wr_ctl;
    logic wr_st;
    logic wr_ch;
    logic wr_cl;
    logic wr_ph;
    logic wr_pl;
    logic rd_st;
    assign take = (avs_read | avs_write) & ~pending_r;
    assign wr_ctl = wr_r & (addr_r == cct_pkg::TIMER_CONTROL_ADDR);
    assign wr_st = wr_r & (addr_r == cct_pkg::TIMER_CONTROL_STATUS_ADDR);
    assign wr_ch = wr_r & (addr_r == cct_pkg::COUNTER_HIGH_BYTE_ADDR);
    assign wr_cl = wr_r & (addr_r == cct_pkg::COUNTER_LOW_BYTE_ADDR);
    assign wr_ph = wr_r & (addr_r == cct_pkg::COMPARE_HIGH_BYTE_ADDR);
    assign wr_pl = wr_r & (addr_r == cct_pkg::COMPARE_LOW_BYTE_ADDR);
    assign rd_st = rd_r & (addr_r == cct_pkg::TIMER_CONTROL_STATUS_ADDR);
    assign wr_ir = wr_r & (addr_r == cct_pkg::IRQ_REQUEST_REG_TWO_ADDR);
    assign wr_ie = wr_r & (addr_r == cct_pkg::IRQ_ENABLE_REG_TWO_ADDR);
    // In 16-bit mode the high byte read parks the low byte in the taking cycle, so the
    // pair read back is one coherent sample of the counter.
    assign rd_ch_now = take & avs_read &
                       (avs_address == cct_pkg::COUNTER_HIGH_BYTE_ADDR);
    assign rd_ph_now = take & avs_read &
                       (avs_address == cct_pkg::COMPARE_HIGH_BYTE_ADDR);

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pending_r <= 1'b0;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            avs_waitrequest <= 1'b1;
        end else begin
            pending_r <= take;
            wr_r <= take & avs_write;
            rd_r <= take & avs_read;
            avs_waitrequest <= ~take;
            if (take) begin
                addr_r <= avs_address;
                wdata_r <= avs_writedata;
            end
        end
    end

    // Read data; the high byte read in 16-bit mode parks the low byte.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            avs_readdata <= cct_pkg::READ_UNMAPPED;
        end else if (take & avs_read) begin
            unique case (avs_address)
                cct_pkg::TIMER_CONTROL_STATUS_ADDR: begin
                    avs_readdata <= status_r;
                end
                cct_pkg::COUNTER_HIGH_BYTE_ADDR: begin
                    avs_readdata <= counter_high_byte_r;
                end
                cct_pkg::COUNTER_LOW_BYTE_ADDR: begin
                    avs_readdata <= sixteen ? temp_r : counter_low_byte_r;
                end
                cct_pkg::COMPARE_HIGH_BYTE_ADDR: begin
                    avs_readdata <= compare_high_byte_r;
                end
                cct_pkg::COMPARE_LOW_BYTE_ADDR: begin
                    avs_readdata <= sixteen ? temp_r : compare_low_byte_r;
                end
                cct_pkg::IRQ_REQUEST_REG_TWO_ADDR: begin
                    avs_readdata <= {6'h00, irq_request_reg_two_r};
                end
                cct_pkg::IRQ_ENABLE_REG_TWO_ADDR: begin
                    avs_readdata <= {6'h00, irq_enable_reg_two_r};
                end
                default: begin
                    avs_readdata <= cct_pkg::READ_UNMAPPED;
                end
            endcase
        end
    end

    // Temporary byte: high write parks, low write commits both halves.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            temp_r <= 8'h00;
        end else if (sixteen) begin
            if (wr_ch | wr_ph) begin
                temp_r <= wdata_r;
            end else if (rd_ch_now) begin
                temp_r <= counter_low_byte_r;
            end else if (rd_ph_now) begin
                temp_r <= compare_low_byte_r;
            end
        end
    end

    // Timer control is write-only; software keeps its own copy of it.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            timer_control_r <= cct_pkg::TIMER_CONTROL_RST;
        end else if (wr_ctl) begin
            timer_control_r <= wdata_r;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            compare_high_byte_r <= cct_pkg::COMPARE_RST;
            compare_low_byte_r <= cct_pkg::COMPARE_RST;
        end else if (sixteen) begin
            if (wr_pl) begin
                compare_high_byte_r <= temp_r;
                compare_low_byte_r <= wdata_r;
            end
        end else begin
            if (wr_ph) begin
                compare_high_byte_r <= wdata_r;
            end
            if (wr_pl) begin
                compare_low_byte_r <= wdata_r;
            end
        end
    end

    // Counters; a software write beats a count in the same cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_low_byte_r <= cct_pkg::COUNTER_RST;
        end else if (wr_cl) begin
            counter_low_byte_r <= wdata_r;
        end else if (tick_lo) begin
            counter_low_byte_r <= lo_clr ? 8'h00
                                         : counter_low_byte_r + 8'h01;
        end
    end

    // In 16-bit mode only the low byte write commits, so a lone high byte
    // write just parks its value.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            counter_high_byte_r <= cct_pkg::COUNTER_RST;
        end else if (sixteen & wr_cl) begin
            counter_high_byte_r <= temp_r;
        end else if (~sixteen & wr_ch) begin
            counter_high_byte_r <= wdata_r;
        end else if (tick_hi) begin
            counter_high_byte_r <= hi_clr ? 8'h00
                                          : counter_high_byte_r + 8'h01;
        end
    end

    // Flags: a flag read as one may be cleared by writing zero; a hardware
    // set in the same cycle wins over that clear.
    logic [7:0] hw_set;
    logic [7:0] sw_clr;
    assign hw_set = {ev_hi.ovf, ev_hi.cmp, 2'b00,
                     ev_lo.ovf, ev_lo.cmp, 2'b00};
    assign sw_clr = wr_st ? (flag_seen_r & ~wdata_r & cct_pkg::FLAG_MASK)
                          : 8'h00;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= cct_pkg::TIMER_CONTROL_STATUS_RST;
            flag_seen_r <= 8'h00;
        end else begin
            if (wr_st) begin
                status_r <= ((status_r & ~sw_clr) & cct_pkg::FLAG_MASK) |
                            (wdata_r & ~cct_pkg::FLAG_MASK) | hw_set;
                flag_seen_r <= 8'h00;
            end else begin
                status_r <= status_r | hw_set;
                if (rd_st) flag_seen_r <= status_r & cct_pkg::FLAG_MASK;
            end
        end
    end

    // Request bits are sticky; writing one clears, a new event wins.
    logic req_hi;
    logic req_lo;
    assign req_hi = (ev_hi.ovf & status_r[cct_pkg::ST_UPPER_OVF_IE]) |
                    ev_hi.cmp;
    assign req_lo = (ev_lo.ovf & status_r[cct_pkg::ST_LOWER_OVF_IE]) |
                    ev_lo.cmp;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq_request_reg_two_r <= IRQ_RST[1:0];
            irq_enable_reg_two_r <= IRQ_RST[1:0];
        end else begin
            irq_request_reg_two_r <= (irq_request_reg_two_r &
                ~(wr_ir ? wdata_r[1:0] : 2'b00)) | {req_hi, req_lo};
            if (wr_ie) begin
                irq_enable_reg_two_r <= wdata_r[1:0];
            end
        end
    end

    // The interrupt output is registered, so it trails a request by a cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_request_reg_two_r & irq_enable_reg_two_r);
        end
    end

    // Pins: a level write sets the pin; a compare event inverts the pin of its half, and in 16-bit mode only the upper pin toggles.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            upper_toggle_pin <= 1'b0;
            lower_toggle_pin <= 1'b0;
        end else if (wr_ctl) begin
            upper_toggle_pin <= wdata_r[cct_pkg::TC_UPPER_LEVEL];
            lower_toggle_pin <= wdata_r[cct_pkg::TC_LOWER_LEVEL];
        end else begin
            if (ev_hi.cmp) begin
                upper_toggle_pin <= ~upper_toggle_pin;
            end
            if (ev_lo.cmp) begin
                lower_toggle_pin <= ~lower_toggle_pin;
            end
        end
    end
endmodule : cct_timer

/* File: common/cct_pkg.sv */
// Package of register map, field positions and types for the compare timer.
package cct_pkg;
    localparam logic [15:0] TIMER_CONTROL_ADDR = 16'hFFB6;
    localparam logic [15:0] TIMER_CONTROL_STATUS_ADDR = 16'hFFB7;
    localparam logic [15:0] COUNTER_HIGH_BYTE_ADDR = 16'hFFB8;
    localparam logic [15:0] COUNTER_LOW_BYTE_ADDR = 16'hFFB9;
    localparam logic [15:0] COMPARE_HIGH_BYTE_ADDR = 16'hFFBA;
    localparam logic [15:0] COMPARE_LOW_BYTE_ADDR = 16'hFFBB;
    localparam logic [15:0] IRQ_REQUEST_REG_TWO_ADDR = 16'hFFBC;
    localparam logic [15:0] IRQ_ENABLE_REG_TWO_ADDR = 16'hFFBD;
    localparam logic [7:0] TIMER_CONTROL_RST = 8'h00;
    localparam logic [7:0] TIMER_CONTROL_STATUS_RST = 8'h00;
    localparam logic [7:0] COUNTER_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'hFF;
    localparam logic [7:0] IRQ_RST = 8'h00;
    localparam logic [7:0] READ_UNMAPPED = 8'h00;
    // Timer control fields.
    localparam int TC_UPPER_LEVEL = 7;
    localparam int TC_UPPER_SEL_TOP = 6;
    localparam int TC_LOWER_LEVEL = 3;
    localparam int TC_LOWER_SEL_TOP = 2;
    // Control/status fields.
    localparam int ST_UPPER_OVF = 7;
    localparam int ST_UPPER_CMP = 6;
    localparam int ST_UPPER_OVF_IE = 5;
    localparam int ST_UPPER_CLR = 4;
    localparam int ST_LOWER_OVF = 3;
    localparam int ST_LOWER_CMP = 2;
    localparam int ST_LOWER_OVF_IE = 1;
    localparam int ST_LOWER_CLR = 0;
    // Interrupt request and enable fields.
    localparam int IRQ_UPPER = 1;
    localparam int IRQ_LOWER = 0;
    localparam logic [7:0] FLAG_MASK = 8'hCC;
    // Prescaler: divide by 32 is the largest tap.
    localparam int PRESCALE_BITS = 5;
    typedef struct packed {
        logic ovf;
        logic cmp;
    } cct_event_t;
endpackage : cct_pkg

/* File: bench/cct_timer_checker.sv */
// Port-level assertions for the compare timer, bound to its top module.
`timescale 1ns/100ps
module cct_timer_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [15:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [7:0] avs_writedata,
    input wire logic [7:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic event_input_pin,
    input wire logic event_rising,
    input wire logic upper_toggle_pin,
    input wire logic lower_toggle_pin,
    input wire logic irq
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    logic req;
    logic hole;
    logic tc_hit;
    logic up_lvl;
    logic lo_lvl;
    assign req = avs_read || avs_write;
    // Timer control is write-only, so it reads back like a hole in the map.
    assign hole = avs_address <= cct_pkg::TIMER_CONTROL_ADDR
        || avs_address > cct_pkg::IRQ_ENABLE_REG_TWO_ADDR;
    assign tc_hit = avs_write && !avs_waitrequest
        && avs_address == cct_pkg::TIMER_CONTROL_ADDR;
    assign up_lvl = avs_writedata[cct_pkg::TC_UPPER_LEVEL];
    assign lo_lvl = avs_writedata[cct_pkg::TC_LOWER_LEVEL];
    sequence s_taken;
        $rose(req) && avs_waitrequest;
    endsequence
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    a_answer_time: assert property (s_taken |-> ##1 s_answer)
        else $error("bus answer not one cycle after request");
    a_wait_pulse: assert property ($fell(avs_waitrequest) |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_idle_wait: assert property (!req |-> avs_waitrequest)
        else $error("waitrequest low with no request");
    a_wait_bound: assert property (req && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest)
        else $error("request not answered in time");
    a_hole_reads: assert property (avs_read && !avs_waitrequest && hole
        |-> avs_readdata == cct_pkg::READ_UNMAPPED)
        else $error("unmapped or write-only read not zero");
    a_data_hold: assert property ($changed(avs_readdata) |-> $past(avs_read))
        else $error("read data changed without a read");
    a_pin_level: assert property (tc_hit |=>
        upper_toggle_pin == $past(up_lvl) && lower_toggle_pin == $past(lo_lvl))
        else $error("output pin level not taken from write");
    a_irq_fall: assert property ($fell(irq) |->
        $past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
        else $error("interrupt dropped without software write");
endmodule : cct_timer_checker

bind cct_timer cct_timer_checker i_chk (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .event_input_pin(event_input_pin),
    .event_rising(event_rising), .upper_toggle_pin(upper_toggle_pin),
    .lower_toggle_pin(lower_toggle_pin), .irq(irq)
);

/* File: bench/cct_timer_tb.sv */
// Self-checking bench for the cascadable compare timer.
`timescale 1ns/100ps
module cct_timer_tb;
    localparam logic [15:0] A_TC = cct_pkg::TIMER_CONTROL_ADDR;
    localparam logic [15:0] A_ST = cct_pkg::TIMER_CONTROL_STATUS_ADDR;
    localparam logic [15:0] A_CH = cct_pkg::COUNTER_HIGH_BYTE_ADDR;
    localparam logic [15:0] A_CL = cct_pkg::COUNTER_LOW_BYTE_ADDR;
    localparam logic [15:0] A_MH = cct_pkg::COMPARE_HIGH_BYTE_ADDR;
    localparam logic [15:0] A_ML = cct_pkg::COMPARE_LOW_BYTE_ADDR;
    localparam logic [15:0] A_IR = cct_pkg::IRQ_REQUEST_REG_TWO_ADDR;
    localparam logic [15:0] A_IE = cct_pkg::IRQ_ENABLE_REG_TWO_ADDR;
    logic clk, rstn, avs_read, avs_write, avs_waitrequest, irq;
    logic [15:0] avs_address;
    logic [7:0] avs_writedata, avs_readdata, q, hi;
    logic event_input_pin, event_rising, upper_toggle_pin, lower_toggle_pin;
    logic ok;
    int n_mismatch = 0;
    int cmp_count = 0;
    int dv[4] = '{32, 16, 4, 2};
    int e;
    int n;
    cct_timer i_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .event_input_pin(event_input_pin),
        .event_rising(event_rising), .upper_toggle_pin(upper_toggle_pin),
        .lower_toggle_pin(lower_toggle_pin), .irq(irq));
    always #10 clk = ~clk;
    task automatic final_report();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report
    task automatic chk(input logic [7:0] got, exp, m);
        cmp_count++;
        if ((got & m) !== (exp & m)) begin
            n_mismatch++;
            $display("MISMATCH %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Waitrequest and read data are registered, so the values seen just
    // after an edge are those that the edge sampled.
    task automatic bus(input logic w, input logic [15:0] a,
        input logic [7:0] d, output logic [7:0] r);
        int k;
        logic done;
        done = 1'b0;
        r = 8'h00;
        @(posedge clk);
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= d;
        for (k = 0; !done; k++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) begin
                r = avs_readdata;
                done = 1'b1;
            end else if (k > 20) begin
                n_mismatch++;
                $display("MISMATCH %0t: bus timeout", $time);
                final_report();
            end
        end
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [7:0] r;
        bus(1'b1, a, d, r);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [7:0] x, m);
        logic [7:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(r, x, m);
    endtask : rd
    task automatic pulse(input int p);
        repeat (p) begin
            @(posedge clk);
            event_input_pin <= 1'b1;
            repeat (4) @(posedge clk);
            event_input_pin <= 1'b0;
            repeat (4) @(posedge clk);
        end
    endtask : pulse
    task automatic pins(input logic [7:0] x, m);
        repeat (2) @(posedge clk);
        chk({5'h00, irq, upper_toggle_pin, lower_toggle_pin}, x, m);
    endtask : pins
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        {avs_read, avs_write, event_input_pin} = 3'h0;
        avs_address = 16'h0000;
        avs_writedata = 8'h00;
        event_rising = 1'b1;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        rd(A_TC, 8'h00, 8'hFF);
        rd(A_ST, 8'h00, 8'hFF);
        rd(A_CH, 8'h00, 8'hFF);
        rd(A_CL, 8'h00, 8'hFF);
        rd(A_MH, 8'hFF, 8'hFF);
        rd(A_ML, 8'hFF, 8'hFF);
        rd(A_IR, 8'h00, 8'hFF);
        rd(A_IE, 8'h00, 8'hFF);
        rd(16'hFFC0, 8'h00, 8'hFF);
        wr(A_ST, 8'hFF);
        rd(A_ST, 8'h33, 8'hFF);
        wr(A_ST, 8'h00);
        wr(A_TC, 8'h88);
        pins(8'h03, 8'h03);
        wr(A_TC, 8'h00);
        pins(8'h00, 8'h03);
        wr(A_CH, 8'h12);
        wr(A_CL, 8'h34);
        rd(A_CH, 8'h12, 8'hFF);
        rd(A_CL, 8'h34, 8'hFF);
        wr(A_CH, 8'h56);
        rd(A_CH, 8'h12, 8'hFF);
        wr(A_CL, 8'h78);
        rd(A_CH, 8'h34, 8'hFF);
        rd(A_CL, 8'h78, 8'hFF);
        wr(A_TC, 8'h40);
        wr(A_CL, 8'h00);
        pulse(5);
        rd(A_CL, 8'h05, 8'hFF);
        event_rising <= 1'b0;
        pulse(3);
        rd(A_CL, 8'h08, 8'hFF);
        event_rising <= 1'b1;
        wr(A_ML, 8'h03);
        wr(A_ST, 8'h01);
        wr(A_CL, 8'h00);
        pulse(5);
        rd(A_CL, 8'h01, 8'hFF);
        pins(8'h01, 8'h03);
        rd(A_ST, 8'h05, 8'h0F);
        rd(A_IR, 8'h01, 8'h01);
        wr(A_IR, 8'h01);
        wr(A_ML, 8'h80);
        wr(A_ST, 8'h02);
        wr(A_CL, 8'hFE);
        wr(A_IE, 8'h01);
        wr(A_TC, 8'h47);
        for (n = 0; n < 200 && irq !== 1'b1; n++) @(posedge clk);
        if (irq !== 1'b1) begin
            n_mismatch++;
            $display("MISMATCH %0t: interrupt wait timeout", $time);
            final_report();
        end
        wr(A_TC, 8'h40);
        rd(A_ST, 8'h0A, 8'h0B);
        rd(A_IR, 8'h01, 8'h01);
        wr(A_IE, 8'h00);
        pins(8'h00, 8'h04);
        wr(A_IE, 8'h01);
        pins(8'h04, 8'h04);
        wr(A_IR, 8'h01);
        pins(8'h00, 8'h04);
        wr(A_ST, 8'h02);
        rd(A_ST, 8'h02, 8'h0B);
        wr(A_TC, 8'h00);
        rd(A_ST, 8'h00, 8'h00);
        wr(A_ST, 8'h20);
        wr(A_CH, 8'hFF);
        wr(A_CL, 8'hFE);
        wr(A_IE, 8'h02);
        pulse(2);
        rd(A_ST, 8'hA0, 8'hA0);
        rd(A_IR, 8'h02, 8'h02);
        pins(8'h04, 8'h04);
        wr(A_ST, 8'h30);
        wr(A_MH, 8'h00);
        wr(A_ML, 8'h02);
        pulse(4);
        rd(A_CH, 8'h00, 8'hFF);
        rd(A_CL, 8'h01, 8'hFF);
        pins(8'h02, 8'h02);
        wr(A_MH, 8'hFF);
        wr(A_ML, 8'hFF);
        wr(A_ST, 8'h00);
        // Window edges depend on prescaler phase, so allow a small spread.
        for (int c = 4; c < 8; c++) begin
            wr(A_TC, 8'h00);
            wr(A_CH, 8'h00);
            wr(A_CL, 8'h00);
            wr(A_TC, {1'b0, c[2:0], 1'b0, c[2:0]});
            repeat (64) @(posedge clk);
            wr(A_TC, 8'h00);
            bus(1'b0, A_CH, 8'h00, hi);
            bus(1'b0, A_CL, 8'h00, q);
            e = 64 / dv[c - 4];
            ok = q >= e - 1 && q <= e + 3 && hi === q;
            chk({7'h00, ok}, 8'h01, 8'hFF);
        end
        final_report();
    end
endmodule : cct_timer_tb
